/* File: src/awd_top.sv */
// Window detector and reference control for a 10-bit converter
//
// Summary of operation
// - Compare each finished word against both limits
// - Hit sets pollable flag and status bit; masked status drives interrupt
// - Limits are high/low byte register pairs
// - Window sense chosen by limit values only
// - Inside: above upper and below lower limit
// - Outside: below lower or above upper limit
// - Single-ended compares unsigned 10-bit values
// - Differential compares signed 10-bit values
// - Ground negative input means single-ended
// - Select bit picks pin or supply reference
// - Bias forced by converter or oscillator enable
// - Reference bias on for its users
// - Temperature sensor enable bit powers sensor
// - Reference register resets zero, upper bits zero
`timescale 1ns/10ps
module awd_top
    import awd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [AWD_AW-1:0] addr_i,
    input wire logic [AWD_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [AWD_DW-1:0] rdata_o,
    input wire logic conv_done_i,
    input wire logic [AWD_CW-1:0] conv_word_i,
    input wire logic [AWD_NW-1:0] negative_input_select_i,
    input wire logic adc_en_i,
    input wire logic osc_en_i,
    input wire logic int_ref_en_i,
    input wire logic clk_mul_en_i,
    output logic window_match_flag_o,
    output logic irq_o,
    output logic ref_source_select_o,
    output logic temp_sensor_on_o,
    output logic conv_bias_on_o,
    output logic ref_buffer_on_o,
    output logic ref_bias_on_o
);
    // ========================================================================
    // Register storage
    // ========================================================================
    logic [AWD_DW-1:0] upper_cmp_limit_high_reg;  // Greater-than high byte
    logic [AWD_DW-1:0] upper_cmp_limit_low_reg;   // Greater-than low byte
    logic [AWD_DW-1:0] lower_cmp_limit_high_reg;  // Less-than high byte
    logic [AWD_DW-1:0] lower_cmp_limit_low_reg;   // Less-than low byte
    logic [AWD_DW-1:0] mask_reg;                  // Interrupt mask
    logic [AWD_DW-1:0] status_reg;                // Sticky events
    logic [AWD_DW-1:0] config_reg;                // Justification
    logic flag_reg;                               // Window match flag
    logic [AWD_DW-1:0] rdata_reg;                 // Read data
    logic irq_reg;                                // Interrupt output
    logic conv_bias_reg;                          // Converter bias output
    logic ref_bias_reg;                           // Reference bias output
    logic [AWD_DW-1:0] refctl_q;                  // Reference register value
    logic conv_bias_next;                         // Converter bias next
    logic ref_bias_next;                          // Reference bias next

    // ========================================================================
    // Address decode
    // ========================================================================
    wire wr_en = ce_i && wr_i;
    wire rd_en = ce_i && rd_i;
    wire sel_uh = addr_i == AWD_OFF_UPPER_HIGH;
    wire sel_ul = addr_i == AWD_OFF_UPPER_LOW;
    wire sel_lh = addr_i == AWD_OFF_LOWER_HIGH;
    wire sel_ll = addr_i == AWD_OFF_LOWER_LOW;
    wire sel_ref = addr_i == AWD_OFF_REFCTL;
    wire sel_st = addr_i == AWD_OFF_STATUS;
    wire sel_mk = addr_i == AWD_OFF_MASK;
    wire sel_cf = addr_i == AWD_OFF_CONFIG;
    wire sel_fl = addr_i == AWD_OFF_FLAG;

    // ========================================================================
    // Limit assembly
    // ========================================================================
    wire [2*AWD_DW-1:0] upper_raw = {upper_cmp_limit_high_reg,
                                     upper_cmp_limit_low_reg};
    wire [2*AWD_DW-1:0] lower_raw = {lower_cmp_limit_high_reg,
                                     lower_cmp_limit_low_reg};
    wire left_just = config_reg[AWD_CFG_LJST_BIT];
    // Limits are held in the result's format; strip justification
    wire [AWD_CW-1:0] upper_lim = left_just ? upper_raw[2*AWD_DW-1:AWD_LJ_SHIFT]
                                            : upper_raw[AWD_CW-1:0];
    wire [AWD_CW-1:0] lower_lim = left_just ? lower_raw[2*AWD_DW-1:AWD_LJ_SHIFT]
                                            : lower_raw[AWD_CW-1:0];
    // Ground on the negative side is single-ended; any other is differential
    wire diff_mode = negative_input_select_i != AWD_NEG_GND;

    // ========================================================================
    // Comparators
    // ========================================================================
    awd_cmp_if c_up ();  // Word versus greater-than limit
    awd_cmp_if c_lo ();  // Word versus less-than limit
    awd_cmp_if c_ll ();  // Less-than limit versus greater-than limit
    assign c_up.word_a = conv_word_i;
    assign c_up.word_b = upper_lim;
    assign c_up.signed_mode = diff_mode;
    assign c_lo.word_a = conv_word_i;
    assign c_lo.word_b = lower_lim;
    assign c_lo.signed_mode = diff_mode;
    assign c_ll.word_a = lower_lim;
    assign c_ll.word_b = upper_lim;
    assign c_ll.signed_mode = diff_mode;
    awd_mag_cmp u_cmp_up (.port_c(c_up));
    awd_mag_cmp u_cmp_lo (.port_c(c_lo));
    awd_mag_cmp u_cmp_ll (.port_c(c_ll));

    // Window sense from limit values alone, no mode bit
    wire inside_mode = c_ll.a_gt_b;
    wire inside_hit = c_up.a_gt_b && c_lo.a_lt_b;
    // Outside the span: under the less-than limit or over the greater-than limit
    wire outside_hit = c_lo.a_lt_b || c_up.a_gt_b;
    // Equal limits select neither window
    wire outside_mode = c_ll.a_lt_b;
    wire win_hit = conv_done_i && ((inside_mode && inside_hit)
                                   || (outside_mode && outside_hit));

    // ========================================================================
    // Reference control
    // ========================================================================
    awd_refctl u_refctl (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_i(wr_i && sel_ref),
        .wdata_i(wdata_i),
        .adc_en_i(adc_en_i),
        .osc_en_i(osc_en_i),
        .int_ref_en_i(int_ref_en_i),
        .clk_mul_en_i(clk_mul_en_i),
        .ctl_o(refctl_q),
        .conv_bias_next_o(conv_bias_next),
        .ref_bias_next_o(ref_bias_next)
    );

    // ========================================================================
    // Next values
    // ========================================================================
    wire [AWD_DW-1:0] events = {{(AWD_DW-2){1'b0}}, conv_done_i, win_hit};
    // Set wins over read-clear
    wire [AWD_DW-1:0] status_next = ((rd_en && sel_st) ? AWD_RST_BYTE : status_reg)
                                    | events;
    // Set wins over write-one clear
    wire flag_next = win_hit
                     | (flag_reg & ~(wr_en && sel_fl && wdata_i[AWD_ST_WIN_BIT]));
    wire irq_next = |(status_next & mask_reg);
    wire [AWD_DW-1:0] rd_mux =
        sel_uh ? upper_cmp_limit_high_reg :
        sel_ul ? upper_cmp_limit_low_reg :
        sel_lh ? lower_cmp_limit_high_reg :
        sel_ll ? lower_cmp_limit_low_reg :
        sel_ref ? refctl_q :
        sel_st ? status_reg :
        sel_mk ? mask_reg :
        sel_cf ? config_reg :
        sel_fl ? {{(AWD_DW-1){1'b0}}, flag_reg} : AWD_RST_BYTE;
    wire [AWD_DW-1:0] rdata_next = rd_en ? rd_mux : AWD_RST_BYTE;

    // ========================================================================
    // Limit and config registers
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            upper_cmp_limit_high_reg <= AWD_RST_BYTE;
            upper_cmp_limit_low_reg <= AWD_RST_BYTE;
            lower_cmp_limit_high_reg <= AWD_RST_BYTE;
            lower_cmp_limit_low_reg <= AWD_RST_BYTE;
            mask_reg <= AWD_RST_BYTE;
            config_reg <= AWD_RST_BYTE;
        end else if (wr_en) begin
            if (sel_uh) upper_cmp_limit_high_reg <= wdata_i;
            if (sel_ul) upper_cmp_limit_low_reg <= wdata_i;
            if (sel_lh) lower_cmp_limit_high_reg <= wdata_i;
            if (sel_ll) lower_cmp_limit_low_reg <= wdata_i;
            if (sel_mk) mask_reg <= wdata_i;
            if (sel_cf) config_reg <= wdata_i;
        end
    end

    // ========================================================================
    // Flags and outputs
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            status_reg <= AWD_RST_BYTE;
            flag_reg <= 1'b0;
            rdata_reg <= AWD_RST_BYTE;
            irq_reg <= 1'b0;
            conv_bias_reg <= 1'b0;
            ref_bias_reg <= 1'b0;
        end else if (ce_i) begin
            status_reg <= status_next;
            flag_reg <= flag_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            conv_bias_reg <= conv_bias_next;
            ref_bias_reg <= ref_bias_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign window_match_flag_o = flag_reg;
    assign irq_o = irq_reg;
    assign ref_source_select_o = refctl_q[AWD_REFSEL_BIT];
    assign temp_sensor_on_o = refctl_q[AWD_TEMP_BIT];
    assign conv_bias_on_o = conv_bias_reg;
    assign ref_buffer_on_o = refctl_q[AWD_REF_BUF_BIT];
    assign ref_bias_on_o = ref_bias_reg;

    // ========================================================================
    // Checks
    // ========================================================================
    chk_flag_sets_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && win_hit |=> flag_reg)
        else $error("window hit did not set flag");
    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flag_reg && !(wr_en && sel_fl) |=> flag_reg)
        else $error("flag dropped without clear");
    chk_inside_cond: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done_i && inside_mode && inside_hit && ce_i |=> flag_reg)
        else $error("inside hit missed");
    chk_outside_cond: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && conv_done_i && outside_mode && (c_lo.a_lt_b || c_up.a_gt_b) |=> flag_reg)
        else $error("outside hit missed");
    chk_mode_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(inside_mode && outside_mode))
        else $error("both window modes");
    chk_irq_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> irq_reg == |($past(status_next) & $past(mask_reg)))
        else $error("irq mismatch");
    chk_ref_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (refctl_q & ~AWD_REFCTL_MASK) == AWD_RST_BYTE)
        else $error("reference upper bits set");
    chk_bias_forced: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && (adc_en_i || osc_en_i) |=> conv_bias_on_o)
        else $error("bias not forced");
    chk_refbias_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && temp_sensor_on_o |=> ref_bias_on_o)
        else $error("reference bias off");
    chk_hit_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !flag_reg && !(ce_i && win_hit) |=> !flag_reg)
        else $error("flag set without hit");
    cov_inside: cover property (@(posedge clk_i) win_hit && inside_mode);
    cov_outside: cover property (@(posedge clk_i) win_hit && outside_mode);
    cov_diff: cover property (@(posedge clk_i) win_hit && diff_mode);
    cov_irq: cover property (@(posedge clk_i) irq_reg);
endmodule

/* File: include/awd_pkg.sv */
// Package: register map, field positions and constants of the window detector block
package awd_pkg;
    // ========================================================================
    // Widths
    // ========================================================================
    localparam int AWD_AW = 8;   // Register address width
    localparam int AWD_DW = 8;   // Register data width
    localparam int AWD_CW = 10;  // Conversion word width
    localparam int AWD_NW = 5;   // Negative input select width

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [7:0] AWD_OFF_UPPER_HIGH = 8'hC4;  // Greater-than limit, high byte
    localparam logic [7:0] AWD_OFF_UPPER_LOW = 8'hC3;   // Greater-than limit, low byte
    localparam logic [7:0] AWD_OFF_LOWER_HIGH = 8'hC6;  // Less-than limit, high byte
    localparam logic [7:0] AWD_OFF_LOWER_LOW = 8'hC5;   // Less-than limit, low byte
    localparam logic [7:0] AWD_OFF_REFCTL = 8'hD1;      // Reference control
    localparam logic [7:0] AWD_OFF_STATUS = 8'hE0;      // Event status, read clears
    localparam logic [7:0] AWD_OFF_MASK = 8'hE1;        // Event mask
    localparam logic [7:0] AWD_OFF_CONFIG = 8'hE2;      // Format config
    localparam logic [7:0] AWD_OFF_FLAG = 8'hE3;        // Window flag, write 1 clears

    // ========================================================================
    // Reset values and fields
    // ========================================================================
    localparam logic [7:0] AWD_RST_BYTE = 8'h00;        // Reset value of all registers
    localparam logic [7:0] AWD_REFCTL_MASK = 8'h0F;     // Implemented reference bits
    localparam int AWD_REF_BUF_BIT = 0;                 // Reference buffer enable
    localparam int AWD_BIAS_BIT = 1;                    // Converter bias enable
    localparam int AWD_TEMP_BIT = 2;                    // Temperature sensor enable
    localparam int AWD_REFSEL_BIT = 3;                  // Reference source select
    localparam int AWD_CFG_LJST_BIT = 0;                // Left-justified limits
    localparam int AWD_ST_WIN_BIT = 0;                  // Window event status bit
    localparam int AWD_ST_DONE_BIT = 1;                 // Conversion done status bit
    localparam logic [4:0] AWD_NEG_GND = 5'h1F;         // Negative select = ground
    localparam int AWD_LJ_SHIFT = 6;                    // Left-justify shift
endpackage

/* File: include/awd_cmp_if.sv */
// Interface: one limit comparison between the main block and a comparator
`timescale 1ns/10ps
interface awd_cmp_if;
    import awd_pkg::*;
    logic [AWD_CW-1:0] word_a;  // Left operand
    logic [AWD_CW-1:0] word_b;  // Right operand
    logic signed_mode;          // Two's complement compare
    logic a_gt_b;               // Left strictly greater
    logic a_lt_b;               // Left strictly less
    modport user (output word_a, output word_b, output signed_mode,
                  input a_gt_b, input a_lt_b);
    modport cmp (input word_a, input word_b, input signed_mode,
                 output a_gt_b, output a_lt_b);
endinterface

/* File: src/awd_mag_cmp.sv */
// Magnitude comparator of two 10-bit words, signed or unsigned
`timescale 1ns/10ps
module awd_mag_cmp
    import awd_pkg::*;
(
    awd_cmp_if.cmp port_c
);
    // ========================================================================
    // Compare
    // ========================================================================
    // Flip sign bits so one unsigned compare serves both formats
    wire [AWD_CW-1:0] a_adj = {port_c.word_a[AWD_CW-1] ^ port_c.signed_mode,
                               port_c.word_a[AWD_CW-2:0]};
    wire [AWD_CW-1:0] b_adj = {port_c.word_b[AWD_CW-1] ^ port_c.signed_mode,
                               port_c.word_b[AWD_CW-2:0]};
    assign port_c.a_gt_b = a_adj > b_adj;
    assign port_c.a_lt_b = a_adj < b_adj;
endmodule

/* File: src/awd_refctl.sv */
// Reference control register and derived bias enables
`timescale 1ns/10ps
module awd_refctl
    import awd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [AWD_DW-1:0] wdata_i,
    input wire logic adc_en_i,
    input wire logic osc_en_i,
    input wire logic int_ref_en_i,
    input wire logic clk_mul_en_i,
    output logic [AWD_DW-1:0] ctl_o,
    output logic conv_bias_next_o,
    output logic ref_bias_next_o
);
    // ========================================================================
    // Register
    // ========================================================================
    logic [AWD_DW-1:0] ctl_reg;  // Stored bits, upper nibble always zero

    // Only the low nibble stores; upper bits ignore writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctl_reg <= AWD_RST_BYTE;
        end else if (ce_i && wr_i) begin
            ctl_reg <= wdata_i & AWD_REFCTL_MASK;
        end
    end

    assign ctl_o = ctl_reg;
    // Bias forced while converter or oscillator runs
    assign conv_bias_next_o = ctl_reg[AWD_BIAS_BIT] | adc_en_i | osc_en_i;
    // Reference bias follows its users
    assign ref_bias_next_o = int_ref_en_i | ctl_reg[AWD_TEMP_BIT]
                             | clk_mul_en_i;
endmodule

/* File: testbench/awd_conv_model.sv */
// Converter core model that hands finished conversion words to the detector
`timescale 1ns/10ps
module awd_conv_model
    import awd_pkg::*;
(
    input wire logic clk_i,
    output logic conv_done_o,
    output logic [AWD_CW-1:0] conv_word_o,
    output logic [AWD_NW-1:0] negative_input_select_o
);
    // ========================================================================
    // Idle state: no conversion, ground as negative input
    // ========================================================================
    initial begin
        conv_done_o = 1'b0;
        conv_word_o = '0;
        negative_input_select_o = AWD_NEG_GND;
    end

    // Negative input choice, held as a level
    task automatic set_neg(input logic [AWD_NW-1:0] sel);
        negative_input_select_o <= sel;
    endtask

    // One finished conversion: word valid only beside the done strobe
    task automatic convert(input logic [AWD_CW-1:0] word);
        @(posedge clk_i);
        conv_done_o <= 1'b1;
        conv_word_o <= word;
        @(posedge clk_i);
        conv_done_o <= 1'b0;
        // Stale word shown inverted so a late sample cannot pass by luck
        conv_word_o <= ~word;
    endtask
endmodule

/* File: testbench/awd_top_test.sv */
// Self-checking testbench of the window detector and reference control block
`timescale 1ns/10ps
module awd_top_test;
    import awd_pkg::*;
    // ========================================================================
    // Signals
    // ========================================================================
    logic clk_i;
    logic rst_n_i;
    logic ce_i;
    logic [AWD_AW-1:0] addr_i;
    logic [AWD_DW-1:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [AWD_DW-1:0] rdata_o;
    logic conv_done_i;
    logic [AWD_CW-1:0] conv_word_i;
    logic [AWD_NW-1:0] neg_sel;
    logic [3:0] en_vec; // Neighbour enables: adc, osc, int ref, clk mul
    logic window_match_flag_o;
    logic irq_o;
    wire [4:0] ana_o; // Ref select, temp, conv bias, buffer, ref bias
    logic [AWD_DW-1:0] rd_val;
    int error_cnt;
    int tests_run;

    // ========================================================================
    // Design and converter model
    // ========================================================================
    awd_top u_awd_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .conv_done_i(conv_done_i), .conv_word_i(conv_word_i),
        .negative_input_select_i(neg_sel), .adc_en_i(en_vec[3]), .osc_en_i(en_vec[2]),
        .int_ref_en_i(en_vec[1]), .clk_mul_en_i(en_vec[0]),
        .window_match_flag_o(window_match_flag_o), .irq_o(irq_o),
        .ref_source_select_o(ana_o[4]), .temp_sensor_on_o(ana_o[3]),
        .conv_bias_on_o(ana_o[2]), .ref_buffer_on_o(ana_o[1]), .ref_bias_on_o(ana_o[0]));
    awd_conv_model u_awd_conv_model (.clk_i(clk_i), .conv_done_o(conv_done_i),
        .conv_word_o(conv_word_i), .negative_input_select_o(neg_sel));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data sampled in the single cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
        chk({8'h00, rd_val}, {8'h00, exp});
    endtask
    // Limits as 16-bit pairs in the configured justification: high byte holds bits 15:8
    task automatic set_limits(input logic [15:0] gt, input logic [15:0] lt);
        reg_wr(AWD_OFF_UPPER_HIGH, gt[15:8]);
        reg_wr(AWD_OFF_UPPER_LOW, gt[7:0]);
        reg_wr(AWD_OFF_LOWER_HIGH, lt[15:8]);
        reg_wr(AWD_OFF_LOWER_LOW, lt[7:0]);
    endtask
    // One conversion against fresh limits, then flag and status cleared
    task automatic win_case(input logic [4:0] n, input logic [15:0] gt, input logic [15:0] lt,
                            input logic [9:0] w, input logic e);
        set_limits(gt, lt);
        u_awd_conv_model.set_neg(n);
        u_awd_conv_model.convert(w);
        @(posedge clk_i);
        #1 chk({15'h0, window_match_flag_o}, {15'h0, e});
        reg_wr(AWD_OFF_FLAG, 8'h01);
        rd_chk(AWD_OFF_STATUS, {6'h0, 1'b1, e});
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ========================================================================
    // Clock and watchdog
    // ========================================================================
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #(40 * 20000);
        error_cnt++;
        final_report;
    end

    // ========================================================================
    // Test sequence
    // ========================================================================
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        addr_i = '0;
        wdata_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        en_vec = 4'h0;
        error_cnt = 0;
        tests_run = 0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values, unmapped place, read data standing one cycle
        rd_chk(AWD_OFF_REFCTL, AWD_RST_BYTE);
        chk({9'h0, ana_o, irq_o, window_match_flag_o}, 16'h0000);
        rd_chk(8'h00, 8'h00);
        reg_wr(8'h00, 8'hA5);
        rd_chk(8'h00, 8'h00);
        reg_wr(AWD_OFF_REFCTL, 8'hFF);
        rd_chk(AWD_OFF_REFCTL, AWD_REFCTL_MASK);
        @(posedge clk_i);
        #1 chk({8'h0, rdata_o}, 16'h0000);
        chk({11'h0, ana_o}, 16'h001F);
        reg_wr(AWD_OFF_REFCTL, 8'h08);
        @(posedge clk_i);
        #1 chk({11'h0, ana_o}, 16'h0010);
        reg_wr(AWD_OFF_REFCTL, 8'h02);
        @(posedge clk_i);
        #1 chk({11'h0, ana_o}, 16'h0004);
        reg_wr(AWD_OFF_REFCTL, 8'h00);
        // Each neighbour enable alone forces its bias generator
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            en_vec <= 4'h8 >> i;
            repeat (2) @(posedge clk_i);
            #1 chk({11'h0, ana_o}, (i < 2) ? 16'h0004 : 16'h0001);
        end
        en_vec <= 4'h0;
        // Interrupt raised, sticky flag, polled flag, read clears status
        reg_wr(AWD_OFF_MASK, 8'h01);
        set_limits(16'h0040, 16'h0080);
        u_awd_conv_model.convert(10'h050);
        @(posedge clk_i);
        #1 chk({14'h0, irq_o, window_match_flag_o}, 16'h0003);
        u_awd_conv_model.convert(10'h000);
        @(posedge clk_i);
        #1 chk({15'h0, window_match_flag_o}, 16'h0001);
        rd_chk(AWD_OFF_FLAG, 8'h01);
        rd_chk(AWD_OFF_STATUS, 8'h03);
        @(posedge clk_i);
        #1 chk({15'h0, irq_o}, 16'h0000);
        rd_chk(AWD_OFF_STATUS, 8'h00);
        // Masked event sets status but leaves the interrupt low
        reg_wr(AWD_OFF_MASK, 8'h00);
        u_awd_conv_model.convert(10'h060);
        repeat (2) @(posedge clk_i);
        #1 chk({15'h0, irq_o}, 16'h0000);
        reg_wr(AWD_OFF_FLAG, 8'h01);
        @(posedge clk_i);
        #1 chk({15'h0, window_match_flag_o}, 16'h0000);
        rd_chk(AWD_OFF_STATUS, 8'h03);
        // Inside window, single-ended, boundaries
        win_case(5'h1F, 16'h0040, 16'h0080, 10'h040, 1'b0);
        win_case(5'h1F, 16'h0040, 16'h0080, 10'h041, 1'b1);
        win_case(5'h1F, 16'h0040, 16'h0080, 10'h07F, 1'b1);
        win_case(5'h1F, 16'h0040, 16'h0080, 10'h080, 1'b0);
        // Outside window chosen by limit order alone; last case equal limits, which select no window
        win_case(5'h1F, 16'h0080, 16'h0040, 10'h03F, 1'b1);
        win_case(5'h1F, 16'h0080, 16'h0040, 10'h040, 1'b0);
        win_case(5'h1F, 16'h0080, 16'h0040, 10'h080, 1'b0);
        win_case(5'h1F, 16'h0080, 16'h0040, 10'h081, 1'b1);
        win_case(5'h1F, 16'h0080, 16'h0080, 10'h000, 1'b0);
        // Differential: signed compare, any non-ground negative input; last case single-ended for contrast
        win_case(5'h00, 16'hFFFF, 16'h0040, 10'h000, 1'b1);
        win_case(5'h00, 16'hFFFF, 16'h0040, 10'h200, 1'b0);
        win_case(5'h1E, 16'hFFFF, 16'h0040, 10'h3FF, 1'b0);
        win_case(5'h1E, 16'hFFFF, 16'h0040, 10'h03F, 1'b1);
        win_case(5'h01, 16'h0040, 16'hFFFF, 10'h3FE, 1'b1);
        win_case(5'h01, 16'h0040, 16'hFFFF, 10'h000, 1'b0);
        win_case(5'h1F, 16'h03FF, 16'h0040, 10'h200, 1'b0);
        // Clock enable low freezes register writes
        @(posedge clk_i);
        ce_i <= 1'b0;
        reg_wr(AWD_OFF_MASK, 8'hFF);
        ce_i <= 1'b1;
        rd_chk(AWD_OFF_MASK, 8'h00);
        // Left-justified limits: value sits in bits 15:6 of the pair
        reg_wr(AWD_OFF_CONFIG, 8'h01);
        rd_chk(AWD_OFF_CONFIG, 8'h01);
        win_case(5'h1F, 16'h1000, 16'h2000, 10'h041, 1'b1);
        win_case(5'h1F, 16'h1000, 16'h2000, 10'h040, 1'b0);
        win_case(5'h1F, 16'h2000, 16'h1000, 10'h081, 1'b1);
        final_report;
    end
endmodule
